// File: pkg/pmcd_defines.svh
// Register offsets, field positions, reset values and timing counts of the power control block.
// Assumes an AHB-Lite slave decode of the low address bits only.
`ifndef PMCD_DEFINES_SVH
`define PMCD_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define PMCD_OFS_MODE 8'h00
`define PMCD_OFS_PERIPH_EN 8'h04
`define PMCD_OFS_DIV 8'h08
`define PMCD_OFS_STATUS 8'h0C
`define PMCD_OFS_WAKE_EN 8'h10

// ==========================================================
// Fields
`define PMCD_MODE_IDLE_BIT 0
`define PMCD_MODE_PDOWN_BIT 1
`define PMCD_NUM_PERIPH 8
`define PMCD_NUM_WAKE 4

// ==========================================================
// Reset values
`define PMCD_PERIPH_EN_RST 8'hFF
`define PMCD_DIV_RST 2'h0
`define PMCD_WAKE_EN_RST 4'h0

// ==========================================================
// Timing: oscillator start-up wait after power-down
`define PMCD_OSC_WAIT_US 100
`define PMCD_CLK_MHZ 100
`define PMCD_OSC_WAIT_CYC (`PMCD_OSC_WAIT_US * `PMCD_CLK_MHZ)

`endif

// File: pkg/pmcd_pkg.sv
// Types of the power mode and peripheral clock divider block.
// Assumes pmcd_defines.svh holds all numeric constants.
package pmcd_pkg;

  // ==========================================================
  // Divider setting as held in the divide register
  typedef enum logic [1:0] {
    PMCD_DIV_QUARTER = 2'h0,
    PMCD_DIV_FULL = 2'h1,
    PMCD_DIV_HALF = 2'h2
  } pmcd_div_t;

  // ==========================================================
  // Power state machine, one-hot
  typedef enum logic [3:0] {
    PMCD_RUN = 4'b0001,
    PMCD_IDLE = 4'b0010,
    PMCD_PDOWN = 4'b0100,
    PMCD_WAKE = 4'b1000
  } pmcd_state_t;

endpackage : pmcd_pkg

// File: rtl/pmcd_clk_div.sv
// Peripheral clock enable generator: full, half or quarter of the processor clock.
// Assumes the caller gates the peripheral clock with the pulse it produces.
`include "pmcd_defines.svh"

module pmcd_clk_div (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic [1:0] div_sel,
  input wire logic run,
  // Output
  output logic periph_tick,
  output logic [1:0] div_active
);

  logic [1:0] count;
  logic wrap;

  // ==========================================================
  // A period ends when the count reaches one less than the active divide ratio
  always_comb begin
    unique case (div_active)
      pmcd_pkg::PMCD_DIV_FULL: wrap = 1'b1;
      pmcd_pkg::PMCD_DIV_HALF: wrap = (count == 2'h1);
      default: wrap = (count == 2'h3);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= 2'h0;
    end else if (run) begin
      count <= wrap ? 2'h0 : count + 2'h1;
    end
  end

  // New setting only adopted at a period boundary, never mid-pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_active <= `PMCD_DIV_RST; // [R8]
    end else if (run && wrap) begin
      div_active <= div_sel; // [R11]
    end
  end

  assign periph_tick = run && wrap; // [R7]

endmodule : pmcd_clk_div

// File: rtl/pmcd_top.sv
// Power mode control, per-peripheral clock enables and peripheral clock divider.
// Assumes clock gates downstream honour the enable outputs; AHB-Lite single slave.
// What this block does
// R1: Idle stops processor, memory and bus clocks
// R2: Idle keeps peripherals clocked; interrupt wakes processor
// R3: Power-down stops oscillator and all clocks
// R4: Power-down retains state and holds outputs
// R5: Reset or clockless interrupt ends power-down
// R6: Each peripheral has its own clock enable
// R7: Peripheral clock is full, half, quarter rate
// R8: Divider resets to quarter rate
// R9: PLL stays running during Idle
// R10: Wake waits for stable oscillator before clocks
// R11: Divider changes only on clean clock boundary
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`include "pmcd_defines.svh"

module pmcd_top #(
  parameter int OSC_WAIT_CYC = `PMCD_OSC_WAIT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Wake sources
  input wire logic irq_pending,
  input wire logic [`PMCD_NUM_WAKE-1:0] ext_wake,
  // Oscillator and PLL
  input wire logic osc_stable,
  input wire logic pll_on_req,
  output logic osc_enable,
  output logic pll_enable,
  // Clock enables and pin hold
  output logic cpu_clk_en,
  output logic mem_bus_clk_en,
  output logic periph_tick,
  output logic [`PMCD_NUM_PERIPH-1:0] periph_clk_en,
  output logic pin_hold
);

  pmcd_pkg::pmcd_state_t state;
  pmcd_pkg::pmcd_state_t next_state;
  logic [1:0] mode;
  logic [`PMCD_NUM_PERIPH-1:0] periph_en;
  logic [1:0] div_sel;
  logic [1:0] div_active;
  logic [`PMCD_NUM_WAKE-1:0] wake_en;
  logic pll_was_on;
  logic [31:0] wait_cnt;
  logic osc_s1, osc_s2, osc_s3, osc_ok;
  logic [`PMCD_NUM_WAKE-1:0] ew_s1, ew_s2, ew_s3, ew_ok;
  logic wake_hit;
  logic ph_we;
  logic rd_take;
  logic [7:0] ph_addr;
  logic mode_clear;

  // ==========================================================
  // Pin synchronisers: a change counts when stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      osc_ok <= 1'b0;
    end else begin
      osc_s1 <= osc_stable;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      if (osc_s2 == osc_s3) begin
        osc_ok <= osc_s3;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PMCD_NUM_WAKE; gi++) begin : g_wake_sync
      always_ff @(posedge core_clk) begin
        if (rst) begin
          ew_s1[gi] <= 1'b0;
          ew_s2[gi] <= 1'b0;
          ew_s3[gi] <= 1'b0;
          ew_ok[gi] <= 1'b0;
        end else begin
          ew_s1[gi] <= ext_wake[gi];
          ew_s2[gi] <= ew_s1[gi];
          ew_s3[gi] <= ew_s2[gi];
          if (ew_s2[gi] == ew_s3[gi]) begin
            ew_ok[gi] <= ew_s3[gi];
          end
        end
      end
    end
  endgenerate

  // Only enabled level-type sources can act without a running clock
  assign wake_hit = |(ew_ok & wake_en); // [R5]

  // ==========================================================
  // AHB-Lite: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Read data loads in the address phase so it stands through the data phase
  assign rd_take = hready && hsel && htrans[1] && !hwrite;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ph_we <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_we <= hsel && htrans[1] && hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  // ==========================================================
  // Mode register: cleared by hardware once the mode is left
  assign mode_clear = (state == pmcd_pkg::PMCD_IDLE && next_state != pmcd_pkg::PMCD_IDLE)
    || (state == pmcd_pkg::PMCD_WAKE && next_state == pmcd_pkg::PMCD_RUN);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode <= 2'h0;
    end else if (ph_we && ph_addr == `PMCD_OFS_MODE) begin
      mode <= hwdata[1:0];
    end else if (mode_clear) begin
      mode <= 2'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      periph_en <= `PMCD_PERIPH_EN_RST;
    end else if (ph_we && ph_addr == `PMCD_OFS_PERIPH_EN) begin
      periph_en <= hwdata[`PMCD_NUM_PERIPH-1:0]; // [R6]
    end
  end

  // Reserved code 3 is not stored, so the divider never sees it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_sel <= `PMCD_DIV_RST; // [R8]
    end else if (ph_we && ph_addr == `PMCD_OFS_DIV && hwdata[1:0] != 2'h3) begin
      div_sel <= hwdata[1:0]; // [R7]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_en <= `PMCD_WAKE_EN_RST;
    end else if (ph_we && ph_addr == `PMCD_OFS_WAKE_EN) begin
      wake_en <= hwdata[`PMCD_NUM_WAKE-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      unique case (haddr[7:0])
        `PMCD_OFS_MODE: hrdata <= {30'h0000_0000, mode};
        `PMCD_OFS_PERIPH_EN: hrdata <= {24'h00_0000, periph_en};
        `PMCD_OFS_DIV: hrdata <= {28'h000_0000, div_active, div_sel};
        `PMCD_OFS_STATUS: hrdata <= {26'h000_0000, osc_ok, pll_enable, state};
        `PMCD_OFS_WAKE_EN: hrdata <= {28'h000_0000, wake_en};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Power state machine
  always_comb begin
    next_state = state;
    unique case (state)
      pmcd_pkg::PMCD_RUN: begin
        if (mode[`PMCD_MODE_PDOWN_BIT]) begin
          next_state = pmcd_pkg::PMCD_PDOWN;
        end else if (mode[`PMCD_MODE_IDLE_BIT]) begin
          next_state = pmcd_pkg::PMCD_IDLE;
        end
      end
      pmcd_pkg::PMCD_IDLE: begin
        if (irq_pending) begin
          next_state = pmcd_pkg::PMCD_RUN; // [R2]
        end
      end
      pmcd_pkg::PMCD_PDOWN: begin
        if (wake_hit) begin
          next_state = pmcd_pkg::PMCD_WAKE; // [R5]
        end
      end
      pmcd_pkg::PMCD_WAKE: begin
        if (osc_ok && wait_cnt == 32'h0000_0000) begin
          next_state = pmcd_pkg::PMCD_RUN; // [R10]
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= pmcd_pkg::PMCD_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Wake-up timer starts on leaving power-down
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_cnt <= 32'h0000_0000;
    end else if (state == pmcd_pkg::PMCD_PDOWN && next_state == pmcd_pkg::PMCD_WAKE) begin
      wait_cnt <= 32'(OSC_WAIT_CYC); // [R10]
    end else if (state == pmcd_pkg::PMCD_WAKE && wait_cnt != 32'h0000_0000) begin
      wait_cnt <= wait_cnt - 32'h0000_0001;
    end
  end

  // PLL keeps running through idle if it was on at entry
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pll_was_on <= 1'b0;
    end else if (state == pmcd_pkg::PMCD_RUN) begin
      pll_was_on <= pll_on_req;
    end
  end

  // ==========================================================
  // Clock enables
  logic running;
  logic periph_run;
  assign running = (state == pmcd_pkg::PMCD_RUN);
  assign periph_run = running || (state == pmcd_pkg::PMCD_IDLE); // [R2]

  assign cpu_clk_en = running; // [R1]
  assign mem_bus_clk_en = running; // [R1]
  assign osc_enable = (state != pmcd_pkg::PMCD_PDOWN); // [R3]
  assign pll_enable = running ? pll_on_req
    : ((state == pmcd_pkg::PMCD_IDLE) && pll_was_on); // [R9]
  assign pin_hold = !running && !periph_run; // [R4]

  generate
    for (gi = 0; gi < `PMCD_NUM_PERIPH; gi++) begin : g_periph_gate
      assign periph_clk_en[gi] = periph_run && periph_en[gi]; // [R6] [R3]
    end
  endgenerate

  // Divider is frozen in power-down so its phase is retained
  pmcd_clk_div u_div (
    .core_clk(core_clk),
    .rst(rst),
    .div_sel(div_sel),
    .run(periph_run), // [R4]
    .periph_tick(periph_tick),
    .div_active(div_active)
  );

endmodule : pmcd_top

// File: bench/pmcd_top_sva.sv
// Checker of the power control block, bound to pmcd_top.
// Assumes one clock domain and a synchronous active-high reset.
`include "pmcd_defines.svh"
module pmcd_top_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Observed ports
  input wire logic irq_pending,
  input wire logic osc_stable,
  input wire logic pll_on_req,
  input wire logic osc_enable,
  input wire logic pll_enable,
  input wire logic cpu_clk_en,
  input wire logic mem_bus_clk_en,
  input wire logic periph_tick,
  input wire logic [`PMCD_NUM_PERIPH-1:0] periph_clk_en,
  input wire logic pin_hold
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic idle;
  assign idle = !cpu_clk_en && !pin_hold;
  a_cpu_mem_pair: assert property (cpu_clk_en == mem_bus_clk_en)
    else $error("cpu and memory clock enables differ");
  a_idle_osc_on: assert property (idle |-> osc_enable)
    else $error("oscillator off in idle");
  a_idle_irq_wake: assert property (idle && irq_pending |-> ##1 cpu_clk_en)
    else $error("interrupt did not wake from idle");
  a_pd_all_off: assert property (!osc_enable |-> !cpu_clk_en && !periph_tick
    && periph_clk_en == '0 && !pll_enable) else $error("clock alive in power-down");
  a_pd_pins_held: assert property (!osc_enable |-> pin_hold)
    else $error("pins not held in power-down");
  a_wake_osc_ok: assert property ($fell(pin_hold) && !$past(rst) |->
    $past(osc_stable, 3) && $past(osc_stable, 4)) else $error("woke before oscillator");
  a_pll_idle_held: assert property (idle && $past(idle) |-> $stable(pll_enable))
    else $error("pll changed in idle");
  a_pll_run_follow: assert property (cpu_clk_en |-> pll_enable == pll_on_req)
    else $error("pll enable not following request");
  a_tick_steady: assert property (!pin_hold |-> ##[0:3] (periph_tick || pin_hold))
    else $error("peripheral tick missing");
  c_idle: cover property (idle);
  c_pdown: cover property (!osc_enable);
  c_wake: cover property ($fell(pin_hold));
endmodule : pmcd_top_sva

bind pmcd_top pmcd_top_sva chk (.core_clk(core_clk), .rst(rst), .irq_pending(irq_pending),
  .osc_stable(osc_stable), .pll_on_req(pll_on_req), .osc_enable(osc_enable),
  .pll_enable(pll_enable), .cpu_clk_en(cpu_clk_en), .mem_bus_clk_en(mem_bus_clk_en),
  .periph_tick(periph_tick), .periph_clk_en(periph_clk_en), .pin_hold(pin_hold));

// File: bench/pmcd_partner.sv
// Oscillator and interrupting core model on the far side of the block.
// Assumes the oscillator runs at power-up and needs START_CYC cycles to restart.
module pmcd_partner #(
  parameter int START_CYC = 5
) (
  // Clock
  input wire logic core_clk,
  // From the block
  input wire logic osc_enable,
  input wire logic cpu_clk_en,
  // From the bench
  input wire logic irq_req,
  // To the block
  output logic osc_stable,
  output logic irq_pending
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = START_CYC;
  logic irq_q = 1'b0;
  // Stable only after a real restart delay, so an early wake is visible
  always @(posedge core_clk) begin
    if (!osc_enable) begin
      cnt <= 0;
    end else if (cnt < START_CYC) begin
      cnt <= cnt + 1;
    end
  end
  assign osc_stable = (cnt >= START_CYC);
  // Request stays up until the core runs again
  always @(posedge core_clk) begin
    irq_q <= irq_req | (irq_q & !cpu_clk_en);
  end
  assign irq_pending = irq_q;
endmodule : pmcd_partner

// File: bench/pmcd_top_tb_top.sv
// Self-checking bench of the power control block.
// Assumes pmcd_top as the single AHB-Lite slave with zero wait states.
`include "pmcd_defines.svh"
module pmcd_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OSC_WAIT = 20;
  logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, pll_on_req = 1, irq_req = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] ext_wake = 0;
  logic [7:0] periph_clk_en;
  logic hreadyout, hresp, osc_stable, irq_pending, osc_enable, pll_enable;
  logic cpu_clk_en, mem_bus_clk_en, periph_tick, pin_hold;
  int miscompares = 0, n_compared = 0;
  always #5 core_clk = ~core_clk;
  pmcd_top #(.OSC_WAIT_CYC(OSC_WAIT)) uut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq_pending(irq_pending), .ext_wake(ext_wake), .osc_stable(osc_stable),
    .pll_on_req(pll_on_req), .osc_enable(osc_enable), .pll_enable(pll_enable),
    .cpu_clk_en(cpu_clk_en), .mem_bus_clk_en(mem_bus_clk_en), .periph_tick(periph_tick),
    .periph_clk_en(periph_clk_en), .pin_hold(pin_hold));
  pmcd_partner far (.core_clk(core_clk), .osc_enable(osc_enable),
    .cpu_clk_en(cpu_clk_en), .irq_req(irq_req), .osc_stable(osc_stable),
    .irq_pending(irq_pending));
  // ==========================================
  // Shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : cyc
  // ==========================================
  // Scenarios
  task t_reset;
    xfer(0, `PMCD_OFS_DIV, 0);
    chk(q & 32'h0000_000F, 32'h0000_0000);
    chk(32'({hresp, hreadyout}), 32'h0000_0001);
    xfer(0, `PMCD_OFS_PERIPH_EN, 0);
    chk(q, 32'h0000_00FF);
  endtask : t_reset
  task automatic t_div;
    logic [1:0] sel [3] = '{2'h1, 2'h2, 2'h0};
    int exp [3] = '{16, 8, 4};
    int n;
    for (int i = 0; i < 3; i++) begin
      xfer(1, `PMCD_OFS_DIV, 32'(sel[i]));
      cyc(8);
      n = 0;
      repeat (16) begin
        @(negedge core_clk);
        if (periph_tick === 1'b1) n++;
      end
      chk(32'(n), 32'(exp[i]));
      xfer(0, `PMCD_OFS_DIV, 0);
      chk(q & 32'h0000_000F, 32'({sel[i], sel[i]}));
    end
    xfer(1, `PMCD_OFS_DIV, 3);
    xfer(0, `PMCD_OFS_DIV, 0);
    chk(q & 32'h0000_0003, 32'h0000_0000);
  endtask : t_div
  task t_idle;
    xfer(1, `PMCD_OFS_PERIPH_EN, 32'h0000_005A);
    xfer(1, `PMCD_OFS_MODE, 1);
    cyc(3);
    chk(32'({cpu_clk_en, mem_bus_clk_en}), 0);
    chk(32'(periph_clk_en), 32'h0000_005A);
    @(posedge core_clk);
    pll_on_req <= 1'b0;
    cyc(2);
    chk(32'(pll_enable), 1);
    @(posedge core_clk);
    irq_req <= 1'b1;
    @(posedge core_clk);
    irq_req <= 1'b0;
    cyc(3);
    chk(32'({cpu_clk_en, mem_bus_clk_en}), 3);
    chk(32'(pll_enable), 0);
    @(posedge core_clk);
    pll_on_req <= 1'b1;
  endtask : t_idle
  task automatic t_pdown;
    int n = 0;
    xfer(1, `PMCD_OFS_WAKE_EN, 1);
    xfer(1, `PMCD_OFS_MODE, 2);
    cyc(3);
    chk(32'({osc_enable, pin_hold, periph_clk_en}), 32'h0000_0100);
    @(posedge core_clk);
    ext_wake <= 4'h1;
    while (cpu_clk_en !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    ext_wake <= 4'h0;
    chk(32'(n >= OSC_WAIT && n < 200), 1);
    xfer(0, `PMCD_OFS_PERIPH_EN, 0);
    chk(q, 32'h0000_005A);
    xfer(1, `PMCD_OFS_MODE, 2);
    cyc(3);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    cyc(1);
    chk(32'({cpu_clk_en, osc_enable}), 3);
    xfer(0, `PMCD_OFS_STATUS, 0);
    chk(q & 32'h0000_001F, 32'h0000_0011);
  endtask : t_pdown
  task summarize;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_div();
    t_idle();
    t_pdown();
    summarize();
  end
  initial begin
    #50us;
    miscompares++;
    summarize();
  end
endmodule : pmcd_top_tb_top
